// ===== asf_map.svh
// constants for the alu status flag block: field positions, codes, offsets
// assumes inclusion by bare name from the design files
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH

// ****************************************************************
// status register field positions
// ****************************************************************
`define ASF_BIT_C 3'd0
`define ASF_BIT_DC 3'd1
`define ASF_BIT_Z 3'd2
`define ASF_BIT_OV 3'd3
`define ASF_BIT_N 3'd4
`define ASF_FLAG_MASK 8'h1F
`define ASF_RESET_VAL 8'h00

// ****************************************************************
// register port offsets
// ****************************************************************
`define ASF_OFF_FLAGS 4'h0
`define ASF_OFF_IRQ_STAT 4'h1
`define ASF_OFF_IRQ_MASK 4'h2
`define ASF_OFF_LAST_RES 4'h3

// ****************************************************************
// alu operation codes
// ****************************************************************
`define ASF_OP_PASS 3'h0
`define ASF_OP_ADD 3'h1
`define ASF_OP_SUB 3'h2
`define ASF_OP_RRC 3'h3
`define ASF_OP_RLC 3'h4
`define ASF_OP_AND 3'h5
`define ASF_OP_OR 3'h6
`define ASF_OP_XOR 3'h7

// interrupt status bits: carry, overflow, zero events
`define ASF_IRQ_W 3
`define ASF_IRQ_C 2'd0
`define ASF_IRQ_OV 2'd1
`define ASF_IRQ_Z 2'd2

`endif

// ===== asf_pkg.sv
// types shared by the alu status flag block
// repeats the map header operation codes as literal values
package asf_pkg;
  typedef enum logic [2:0] {
    ASF_PASS = 3'b000,
    ASF_ADD = 3'b001,
    ASF_SUB = 3'b010,
    ASF_RRC = 3'b011,
    ASF_RLC = 3'b100,
    ASF_AND = 3'b101,
    ASF_OR = 3'b110,
    ASF_XOR = 3'b111
  } asf_op_t;
endpackage : asf_pkg

// ===== asf_flag_reg.sv
// flag holding register with per-bit update enables
// assumes synchronous reset and a single clock
`timescale 1ns/1ps
`default_nettype none
module asf_flag_reg #(
  parameter int W = 8
) (
  input wire logic clk_sys, // core clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [W-1:0] rst_val, // value after reset
  input wire logic [W-1:0] wr_en, // per-bit load enable
  input wire logic [W-1:0] wr_val, // per-bit load value
  output logic [W-1:0] q // held value
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // untouched bits keep their old value
  assign q_d = (wr_en & wr_val) | (~wr_en & q_q);
  assign q = q_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q_q <= rst_val;
    end else begin
      q_q <= q_d;
    end
  end

  if (W < 5) begin : g_w_chk
    $error("flag register narrower than five flags");
  end
endmodule : asf_flag_reg
`default_nettype wire

// ===== asf_status_flags.sv
// alu with status flag generation, flag register and register port
// assumes decoder strobes are synchronous to clk_sys and one cycle long
`timescale 1ns/1ps
`default_nettype none
`include "asf_map.svh"
module asf_status_flags #(
  parameter int DW = 8
) (
  input wire logic clk_sys, // core clock, 200 MHz
  input wire logic sys_rst, // sync reset, high
  input wire logic exec_vld, // one instruction executes now
  input wire asf_pkg::asf_op_t exec_op, // alu operation
  input wire logic [DW-1:0] exec_a, // first operand (file/literal)
  input wire logic [DW-1:0] exec_b, // second operand (w)
  input wire logic [4:0] exec_flag_en, // flags this instruction affects
  input wire logic exec_dst_status, // result targets the flag register
  output logic [DW-1:0] exec_res, // registered alu result
  output logic exec_res_vld, // result valid, pulse
  input wire logic [3:0] reg_addr, // register port address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic [7:0] alu_flags, // current flag register
  output logic irq // level interrupt
);

  // ****************************************************************
  // alu arithmetic
  // ****************************************************************
  function automatic logic [DW:0] add_c(input logic [DW-1:0] x,
                                        input logic [DW-1:0] y,
                                        input logic ci);
    add_c = {1'b0, x} + {1'b0, y} + {{DW{1'b0}}, ci};
  endfunction : add_c

  function automatic logic [4:0] add_nib(input logic [3:0] x,
                                         input logic [3:0] y,
                                         input logic ci);
    add_nib = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction : add_nib

  logic [DW-1:0] flags_q;
  wire is_sub = (exec_op == asf_pkg::ASF_SUB);
  wire is_add = (exec_op == asf_pkg::ASF_ADD);
  wire is_arith = is_add | is_sub;
  // subtract adds the inverted operand plus one, so carry = no borrow
  wire [DW-1:0] opnd_b = is_sub ? ~exec_b : exec_b;
  wire carry_in = is_sub;
  wire [DW:0] sum = add_c(exec_a, opnd_b, carry_in);
  wire [4:0] nib = add_nib(exec_a[3:0], opnd_b[3:0], carry_in);
  wire old_c = flags_q[`ASF_BIT_C];
  wire [DW-1:0] rrc_res = {old_c, exec_a[DW-1:1]};
  wire [DW-1:0] rlc_res = {exec_a[DW-2:0], old_c};

  logic [DW-1:0] res;
  always_comb begin
    unique case (exec_op)
      asf_pkg::ASF_PASS: res = exec_a;
      asf_pkg::ASF_ADD: res = sum[DW-1:0];
      asf_pkg::ASF_SUB: res = sum[DW-1:0];
      asf_pkg::ASF_RRC: res = rrc_res;
      asf_pkg::ASF_RLC: res = rlc_res;
      asf_pkg::ASF_AND: res = exec_a & exec_b;
      asf_pkg::ASF_OR: res = exec_a | exec_b;
      asf_pkg::ASF_XOR: res = exec_a ^ exec_b;
    endcase
  end

  // ****************************************************************
  // flag generation
  // ****************************************************************
  wire f_n = res[DW-1];
  // sign changed wrongly: operands agree in sign, result does not
  wire f_ov = is_arith & (exec_a[DW-1] == opnd_b[DW-1])
              & (res[DW-1] != exec_a[DW-1]);
  wire f_z = (res == '0);
  // on subtract these are inverted borrows, straight from the adder
  wire f_dc = nib[4];
  logic f_c;
  always_comb begin
    unique case (exec_op)
      asf_pkg::ASF_RRC: f_c = exec_a[0];
      asf_pkg::ASF_RLC: f_c = exec_a[DW-1];
      default: f_c = sum[DW];
    endcase
  end

  wire [DW-1:0] new_flags = {{(DW-5){1'b0}}, f_n, f_ov, f_z, f_dc, f_c};
  // half carry only meaningful for add and subtract
  wire [4:0] en5 = exec_flag_en
                   & {3'b111, is_arith, 1'b1};
  wire [DW-1:0] flag_upd = exec_vld ? {{(DW-5){1'b0}}, en5} : '0;

  // ****************************************************************
  // flag register write paths
  // ****************************************************************
  // data write to the flag register: alu result or register port
  wire dst_wr = exec_vld & exec_dst_status;
  wire port_wr = reg_wr & (reg_addr == `ASF_OFF_FLAGS);
  wire [DW-1:0] data_val = dst_wr ? res : DW'(reg_wdata);
  wire [DW-1:0] impl_mask = {{(DW-5){1'b0}}, 5'h1F};
  wire [DW-1:0] data_en = (dst_wr | port_wr) ? impl_mask : '0;
  // flag logic wins over a data write on the bits it updates
  wire [DW-1:0] wr_en = flag_upd | data_en;
  wire [DW-1:0] wr_val = (flag_upd & new_flags)
                        | (~flag_upd & data_val);

  asf_flag_reg #(
    .W(DW)
  ) u_flags (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .rst_val(DW'(`ASF_RESET_VAL)),
    .wr_en(wr_en),
    .wr_val(wr_val),
    .q(flags_q)
  );
  assign alu_flags = flags_q[7:0];

  // ****************************************************************
  // result register
  // ****************************************************************
  logic [DW-1:0] res_q;
  logic res_vld_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      res_q <= '0;
      res_vld_q <= 1'b0;
    end else begin
      res_vld_q <= exec_vld;
      if (exec_vld) begin
        res_q <= res;
      end
    end
  end
  assign exec_res = res_q;
  assign exec_res_vld = res_vld_q;

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  logic [2:0] ist_q;
  logic [2:0] imask_q;
  wire [2:0] ev = {3{exec_vld}} & {f_z & en5[2],
                                   f_ov & en5[3],
                                   f_c & en5[0]};
  wire ist_rd = reg_rd & (reg_addr == `ASF_OFF_IRQ_STAT);
  // a new event wins over the read that clears
  wire [2:0] ist_d = ev | (ist_rd ? 3'b000 : ist_q);
  wire mask_wr = reg_wr & (reg_addr == `ASF_OFF_IRQ_MASK);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ist_q <= 3'b000;
      imask_q <= 3'b000;
    end else begin
      ist_q <= ist_d;
      if (mask_wr) begin
        imask_q <= reg_wdata[2:0];
      end
    end
  end
  assign irq = |(ist_q & imask_q);

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `ASF_OFF_FLAGS: rd_mux = flags_q[7:0] & `ASF_FLAG_MASK;
      `ASF_OFF_IRQ_STAT: rd_mux = {5'h00, ist_q};
      `ASF_OFF_IRQ_MASK: rd_mux = {5'h00, imask_q};
      `ASF_OFF_LAST_RES: rd_mux = res_q[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  logic [7:0] rdata_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  if (DW != 8) begin : g_dw_chk
    $error("only an 8-bit datapath is supported");
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_neg;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[4] |=> alu_flags[4] == exec_res[7];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_ovf;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[3] |=> alu_flags[3] ==
      ($past(is_arith) && ($past(exec_a[7]) == $past(opnd_b[7]))
       && (exec_res[7] != $past(exec_a[7])));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[2] |=> alu_flags[2] == (exec_res == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_hc;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[1] && is_add |=> alu_flags[1] ==
      (($past(exec_a[3:0]) + $past(exec_b[3:0])) > 5'h0F);
  endproperty
  a_hc: assert property (p_hc) else $error("half carry wrong");

  property p_carry_add;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[0] && is_add |=> alu_flags[0] ==
      (({1'b0, $past(exec_a)} + {1'b0, $past(exec_b)}) > 9'h0FF);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("add carry");

  property p_borrow;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[0] && is_sub |=> alu_flags[0] ==
      ($past(exec_a) >= $past(exec_b));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow sense");

  property p_sub_res;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && is_sub |=> exec_res == 8'($past(exec_a) - $past(exec_b));
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("sub result");

  property p_rot;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[0] && exec_op == asf_pkg::ASF_RRC
      |=> alu_flags[0] == $past(exec_a[0]);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry");

  property p_dst;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_dst_status && exec_flag_en[2]
      |=> alu_flags[2] == (exec_res == 8'h00);
  endproperty
  a_dst: assert property (p_dst) else $error("status write won");

  property p_keep;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && !exec_dst_status && !exec_flag_en[3] && !reg_wr
      |=> $stable(alu_flags[3]);
  endproperty
  a_keep: assert property (p_keep) else $error("flag changed");

  property p_keep_c;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && !exec_dst_status && !exec_flag_en[0] && !reg_wr
      |=> $stable(alu_flags[0]);
  endproperty
  a_keep_c: assert property (p_keep_c) else $error("carry changed");

  property p_res_vld;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld |=> exec_res_vld;
  endproperty
  a_res_vld: assert property (p_res_vld) else $error("no result");

  property p_res_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !exec_vld |=> $stable(exec_res) && !exec_res_vld;
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result moved");

  property p_rlc;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_flag_en[0] && exec_op == asf_pkg::ASF_RLC
      |=> alu_flags[0] == $past(exec_a[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left carry");

  property p_rrc_res;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_op == asf_pkg::ASF_RRC
      |=> exec_res == {$past(alu_flags[0]), $past(exec_a[7:1])};
  endproperty
  a_rrc_res: assert property (p_rrc_res) else $error("rotate result");

  property p_dst_data;
    @(posedge clk_sys) disable iff (sys_rst)
    exec_vld && exec_dst_status && !exec_flag_en[4]
      |=> alu_flags[4] == exec_res[4];
  endproperty
  a_dst_data: assert property (p_dst_data) else $error("data lost");

  // ****************************************************************
  // register port and subtract checks, the first two built from named steps
  // ****************************************************************
  // a subtract that executes this cycle
  sequence s_sub_ev;
    exec_vld && is_sub;
  endsequence

  // a status read with no instruction beside it, so nothing can set
  sequence s_stat_read;
    reg_rd && (reg_addr == `ASF_OFF_IRQ_STAT) && !exec_vld;
  endsequence

  sequence s_irq_low;
    !irq;
  endsequence

  property p_hc_sub;
    @(posedge clk_sys) disable iff (sys_rst)
    s_sub_ev ##0 exec_flag_en[1]
      |=> alu_flags[1] == ($past(exec_a[3:0]) >= $past(exec_b[3:0]));
  endproperty
  a_hc_sub: assert property (p_hc_sub) else $error("sub half carry");

  property p_rd_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    s_stat_read |=> s_irq_low;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("irq not cleared");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

  property p_port_wr;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_wr && (reg_addr == `ASF_OFF_FLAGS) && !exec_vld
      |=> alu_flags == {3'b000, $past(reg_wdata[4:0])};
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("flag write lost");
endmodule : asf_status_flags
`default_nettype wire

// ===== test_alu_status_flag_logic.sv
// self-checking bench for the alu status flag block
// assumes the design files and the map header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "asf_map.svh"
module test_alu_status_flag_logic;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic exec_vld = 1'b0;
  asf_pkg::asf_op_t exec_op = asf_pkg::ASF_PASS;
  logic [7:0] exec_a = 8'h00;
  logic [7:0] exec_b = 8'h00;
  logic [4:0] exec_flag_en = 5'h00;
  logic exec_dst_status = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] exec_res;
  logic exec_res_vld;
  logic [7:0] reg_rdata;
  logic [7:0] alu_flags;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;
  bit res_chk = 1'b0;
  bit rd_chk = 1'b0;
  logic [7:0] m_flags = 8'h00;
  logic [7:0] m_last = 8'h00;
  logic [2:0] m_stat = 3'h0;
  logic [2:0] m_mask = 3'h0;
  logic [7:0] q_res[$];
  logic [7:0] q_flg[$];
  logic [7:0] q_rd[$];
  // entries: op, a, b, flag enables, status destination
  logic [24:0] corner [12] = '{
    {`ASF_OP_ADD, 8'hFF, 8'h01, 5'h1F, 1'b0},
    {`ASF_OP_ADD, 8'h7F, 8'h01, 5'h1F, 1'b0},
    {`ASF_OP_ADD, 8'h80, 8'h80, 5'h1F, 1'b0},
    {`ASF_OP_SUB, 8'h00, 8'h01, 5'h1F, 1'b0},
    {`ASF_OP_SUB, 8'h05, 8'h05, 5'h1F, 1'b0},
    {`ASF_OP_SUB, 8'h80, 8'h01, 5'h1F, 1'b1},
    {`ASF_OP_RRC, 8'h81, 8'h00, 5'h15, 1'b0},
    {`ASF_OP_RLC, 8'h81, 8'h00, 5'h15, 1'b0},
    {`ASF_OP_AND, 8'hF0, 8'h0F, 5'h14, 1'b1},
    {`ASF_OP_OR, 8'h80, 8'h01, 5'h14, 1'b0},
    {`ASF_OP_XOR, 8'h5A, 8'h5A, 5'h04, 1'b0},
    {`ASF_OP_PASS, 8'h5A, 8'h00, 5'h00, 1'b1}};

  asf_status_flags dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .exec_vld(exec_vld), .exec_op(exec_op), .exec_a(exec_a),
    .exec_b(exec_b), .exec_flag_en(exec_flag_en),
    .exec_dst_status(exec_dst_status), .exec_res(exec_res),
    .exec_res_vld(exec_res_vld), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alu_flags(alu_flags), .irq(irq));

  always #2.5 clk_sys = ~clk_sys;

  // ****************************************************************
  // reference model: {events, flags, result}
  // ****************************************************************
  function automatic logic [18:0] model_op(input logic [2:0] op,
    input logic [7:0] a, input logic [7:0] b, input logic [4:0] en,
    input logic dst, input logic [7:0] old);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [4:0] f;
    logic [4:0] e;
    logic sub;
    logic ar;
    sub = (op == `ASF_OP_SUB);
    ar = sub || (op == `ASF_OP_ADD);
    // subtract adds the inverse plus one, so carries are inverted borrows
    s = {1'b0, a} + {1'b0, sub ? ~b : b} + {8'h00, sub};
    h = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + {4'h0, sub};
    case (op)
      `ASF_OP_ADD, `ASF_OP_SUB: r = s[7:0];
      `ASF_OP_RRC: r = {old[0], a[7:1]};
      `ASF_OP_RLC: r = {a[6:0], old[0]};
      `ASF_OP_AND: r = a & b;
      `ASF_OP_OR: r = a | b;
      `ASF_OP_XOR: r = a ^ b;
      default: r = a;
    endcase
    f[`ASF_BIT_N] = r[7];
    f[`ASF_BIT_OV] = ar && (a[7] ^ b[7] ^ !sub) && (r[7] != a[7]);
    f[`ASF_BIT_Z] = (r == 8'h00);
    f[`ASF_BIT_DC] = h[4];
    f[`ASF_BIT_C] = ar ? s[8] : (op == `ASF_OP_RRC) ? a[0] :
      (op == `ASF_OP_RLC) ? a[7] : old[0];
    e = ar ? en : (en & 5'h1D);
    return {f[2] & e[2], f[3] & e[3], f[0] & e[0],
      3'b000, (f & e) | (~e & (dst ? r[4:0] : old[4:0])), r};
  endfunction : model_op

  // ****************************************************************
  // drivers and comparison
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_op(input logic [24:0] v);
    logic [18:0] r;
    r = model_op(v[24:22], v[21:14], v[13:6], v[5:1], v[0], m_flags);
    @(posedge clk_sys);
    exec_vld <= 1'b1;
    exec_op <= asf_pkg::asf_op_t'(v[24:22]);
    exec_a <= v[21:14];
    exec_b <= v[13:6];
    exec_flag_en <= v[5:1];
    exec_dst_status <= v[0];
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    m_flags = r[15:8];
    m_last = r[7:0];
    m_stat = m_stat | r[18:16];
    q_res.push_back(r[7:0]);
    q_flg.push_back(r[15:8]);
  endtask : do_op

  task automatic reg_acc(input logic wr, input logic [3:0] ad,
    input logic [7:0] d);
    @(posedge clk_sys);
    exec_vld <= 1'b0;
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= ad;
    reg_wdata <= d;
    if (wr && ad == `ASF_OFF_FLAGS) m_flags = {3'b000, d[4:0]};
    if (wr && ad == `ASF_OFF_IRQ_MASK) m_mask = d[2:0];
    if (!wr) begin
      case (ad)
        `ASF_OFF_FLAGS: q_rd.push_back(m_flags);
        `ASF_OFF_IRQ_STAT: q_rd.push_back({5'h00, m_stat});
        `ASF_OFF_IRQ_MASK: q_rd.push_back({5'h00, m_mask});
        `ASF_OFF_LAST_RES: q_rd.push_back(m_last);
        default: q_rd.push_back(8'h00);
      endcase
      if (ad == `ASF_OFF_IRQ_STAT) m_stat = 3'h0;
    end
  endtask : reg_acc

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      exec_vld <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask : idle

  task automatic chk_irq();
    idle(2);
    check({7'h00, irq}, {7'h00, |(m_stat & m_mask)});
  endtask : chk_irq

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // results and read data are sampled one edge after they are taken
  always @(posedge clk_sys) begin
    if (!sys_rst) begin
      check({7'h00, exec_res_vld}, {7'h00, res_chk});
      if (res_chk) begin
        check(exec_res, q_res.pop_front());
        check(alu_flags, q_flg.pop_front());
      end
      check(reg_rdata, rd_chk ? q_rd.pop_front() : 8'h00);
    end
    res_chk = exec_vld && !sys_rst;
    rd_chk = reg_rd && !sys_rst;
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    logic [24:0] v;
    void'($urandom(30653));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(1);
    check(alu_flags, `ASF_RESET_VAL);
    check({7'h00, irq}, 8'h00);
    $display("test reset done");
    foreach (corner[i]) do_op(corner[i]);
    idle(2);
    $display("test corner done");
    repeat (300) begin
      v = {3'($urandom_range(0, 7)), 16'($urandom_range(0, 65535)),
        6'($urandom_range(0, 63))};
      v[0] = ($urandom_range(0, 7) == 0);
      if (v[24:22] > `ASF_OP_RLC || v[24:22] == `ASF_OP_PASS) v[1] = 1'b0;
      do_op(v);
      if ($urandom_range(0, 3) == 0) reg_acc(1'b0, {2'b00, v[3:2]}, 8'h00);
    end
    idle(2);
    $display("test random done");
    reg_acc(1'b1, `ASF_OFF_FLAGS, 8'hFF);
    reg_acc(1'b1, `ASF_OFF_LAST_RES, 8'hA5);
    reg_acc(1'b1, 4'h9, 8'hFF);
    for (int i = 0; i < 16; i++) reg_acc(1'b0, i[3:0], 8'h00);
    $display("test registers done");
    reg_acc(1'b1, `ASF_OFF_IRQ_MASK, 8'h00);
    reg_acc(1'b0, `ASF_OFF_IRQ_STAT, 8'h00);
    do_op({`ASF_OP_ADD, 8'hFF, 8'h01, 5'h1F, 1'b0});
    chk_irq();
    for (int i = 0; i < 3; i++) begin
      reg_acc(1'b1, `ASF_OFF_IRQ_MASK, 8'h01 << i);
      chk_irq();
    end
    reg_acc(1'b0, `ASF_OFF_IRQ_STAT, 8'h00);
    chk_irq();
    do_op({`ASF_OP_ADD, 8'h7F, 8'h01, 5'h1F, 1'b0});
    reg_acc(1'b1, `ASF_OFF_IRQ_MASK, 8'h02);
    chk_irq();
    $display("test interrupt done");
    final_report();
  end
endmodule : test_alu_status_flag_logic
`default_nettype wire
